// >>> src/fpcs_rx_pcs.v
// Summary of operation
// - Plain bit is received bit XOR a locally regenerated scrambler sequence.
// - Lock after 12 consecutive descrambled idle groups (11111); plain bits reach the aligner whether locked or not.
// - On lock a 722 us hold timer starts counting down.
// - A run of 58 idle bit times before expiry restarts the hold timer.
// - Hold expiry drops lock, resets descrambler, reacquires from scratch.
// - Aligner takes descrambler output, or NRZ decoder output when bypassed.
// - Start delimiter 11000 10001 fixes the group boundary for following data.
// - Start delimiter after idles is replaced by preamble nibbles 0101 0101.
// - Groups decode by table to nibbles until end delimiter or two idles.
// - Link-up, enabling transmit and receive coding, after 395 us signal detect.
// - Idle to non-idle without leading start delimiter is a bad start.
// - On bad start, error with nibble 1110 each group until two idles.
// - Each bad start adds exactly one to the false carrier counter.
// - After bad start, error and carrier sense drop on two idles.
// - Fibre mode chosen by strap caught at reset or by select input.
// - Fibre transmit skips scrambling, sends NRZI code bits at 125 MHz.
// - Fibre receive skips descrambling, takes NRZI code bits at 125 MHz.
// - Fibre with no signal sends at least 3 cycles of 84 ones, one zero.
// - Detected far-end fault drops link, so transmitter sends only idles.
// - Group pair 01101 00111 ends nibble conversion.
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_defines.vh"

module fpcs_rx_pcs #(
    parameter LINK_CYC = `FPCS_LINK_CYC,
    parameter HOLD_CYC = `FPCS_HOLD_CYC
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        rx_line,
    input  wire        signal_detect,
    input  wire        fx_strap,
    input  wire        fx_select,
    input  wire        tx_code_bit,
    output reg         tx_line,
    output wire        mii_valid,
    input  wire        mii_ready,
    output wire [3:0]  mii_rxd,
    output wire        mii_rx_dv,
    output wire        mii_rx_er,
    output wire        mii_crs,
    output reg         link_up,
    output reg         descr_locked,
    output wire        fx_mode,
    output reg         far_end_fault,
    output reg         rx_overrun,
    output reg  [15:0] false_carrier_event_counter
);
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_CHECK = 2'd1;
    localparam [1:0] ST_DATA  = 2'd2;
    localparam [1:0] ST_BAD   = 2'd3;
    localparam [16:0] LINK_TOP = LINK_CYC;
    localparam [16:0] HOLD_TOP = HOLD_CYC;

    reg        strap_reg;
    reg        line_prev_reg;
    reg [10:0] dlfsr_reg;
    reg [6:0]  lock_ones_reg;
    reg [16:0] hold_reg;
    reg [16:0] link_cnt_reg;
    reg [6:0]  fef_run_reg;
    reg [1:0]  fef_hits_reg;
    reg [6:0]  fef_tx_cnt_reg;
    reg [1:0]  fef_tx_reps_reg;
    reg        fef_tx_on_reg;
    reg [10:0] tlfsr_reg;
    reg [9:0]  sh_reg;
    reg [6:0]  ones_reg;
    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [2:0]  gcnt_reg;
    reg [2:0]  gcnt_next;
    reg [2:0]  ck_reg;
    reg [2:0]  ck_next;
    reg        tpend_reg;
    reg        tpend_next;
    reg        idle1_reg;
    reg        idle1_next;
    reg        pre_reg;
    reg        pre_next;
    reg        gen_v;
    reg [5:0]  gen_d;
    reg        fcc_inc;
    reg [5:0]  word_reg;
    reg        word_vld_reg;
    reg [4:0]  dec;

    wire       nrz;
    wire       dkey;
    wire       descr;
    wire       plain;
    wire [9:0] sh_n;
    wire [4:0] grp;
    wire       gdone;
    wire       armed;
    wire       buf_in_ready;
    wire       slot_free;
    wire [5:0] buf_out;
    wire       tkey;
    wire       tx_src;
    wire       tx_scr;

    // Decode table: bit 4 flags an invalid group
    function [4:0] dec5;
        input [4:0] g;
        begin
            case (g)
                5'h1E:   dec5 = 5'h00;
                5'h09:   dec5 = 5'h01;
                5'h14:   dec5 = 5'h02;
                5'h15:   dec5 = 5'h03;
                5'h0A:   dec5 = 5'h04;
                5'h0B:   dec5 = 5'h05;
                5'h0E:   dec5 = 5'h06;
                5'h0F:   dec5 = 5'h07;
                5'h12:   dec5 = 5'h08;
                5'h13:   dec5 = 5'h09;
                5'h16:   dec5 = 5'h0A;
                5'h17:   dec5 = 5'h0B;
                5'h1A:   dec5 = 5'h0C;
                5'h1B:   dec5 = 5'h0D;
                5'h1C:   dec5 = 5'h0E;
                5'h1D:   dec5 = 5'h0F;
                default: dec5 = 5'h10;
            endcase
        end
    endfunction

    assign fx_mode = strap_reg | fx_select;
    assign nrz     = rx_line ^ line_prev_reg;
    assign dkey    = dlfsr_reg[10] ^ dlfsr_reg[8];
    assign descr   = nrz ^ dkey;
    assign plain   = fx_mode ? nrz : descr;
    assign sh_n    = {sh_reg[8:0], plain};
    assign grp     = sh_n[4:0];
    assign gdone   = (gcnt_reg == 3'd4);
    assign armed   = (ones_reg >= 7'd`FPCS_ARM_ONES);
    assign slot_free = !word_vld_reg || buf_in_ready;

    // Strap caught while reset is held
    always @(posedge clk) begin
        if (rst) begin
            strap_reg <= fx_strap;
        end
    end

    // Descrambler lock and hold timer
    always @(posedge clk) begin
        if (rst) begin
            line_prev_reg <= 1'b0;
            dlfsr_reg     <= 11'h000;
            lock_ones_reg <= 7'h00;
            hold_reg      <= 17'h00000;
            descr_locked  <= 1'b0;
        end else begin
            line_prev_reg <= rx_line;
            if (!descr_locked) begin
                // While idle is assumed, key is the inverted line bit
                dlfsr_reg <= {dlfsr_reg[9:0], ~nrz};
                if (descr) begin
                    lock_ones_reg <= lock_ones_reg + 7'h01;
                end else begin
                    lock_ones_reg <= 7'h00;
                end
                if (descr && lock_ones_reg == 7'd`FPCS_SYNC_ONES - 7'd1 && !fx_mode) begin
                    descr_locked  <= 1'b1;
                    hold_reg      <= HOLD_TOP;
                    lock_ones_reg <= 7'h00;
                end
            end else if (hold_reg == 17'h00000 || fx_mode) begin
                descr_locked  <= 1'b0;
                dlfsr_reg     <= 11'h000;
                lock_ones_reg <= 7'h00;
            end else begin
                dlfsr_reg <= {dlfsr_reg[9:0], dkey};
                if (descr) begin
                    if (lock_ones_reg != 7'h7F) begin
                        lock_ones_reg <= lock_ones_reg + 7'h01;
                    end
                end else begin
                    lock_ones_reg <= 7'h00;
                end
                if (descr && lock_ones_reg >= 7'd`FPCS_HOLD_ONES - 7'd1) begin
                    hold_reg <= HOLD_TOP;
                end else begin
                    hold_reg <= hold_reg - 17'h00001;
                end
            end
        end
    end

    // Link monitor and far-end fault detection
    always @(posedge clk) begin
        if (rst) begin
            link_cnt_reg  <= 17'h00000;
            link_up       <= 1'b0;
            fef_run_reg   <= 7'h00;
            fef_hits_reg  <= 2'h0;
            far_end_fault <= 1'b0;
        end else begin
            if (nrz) begin
                if (fef_run_reg != 7'h7F) begin
                    fef_run_reg <= fef_run_reg + 7'h01;
                end
                if (fef_run_reg >= 7'd`FPCS_FEF_ONES) begin
                    fef_hits_reg <= 2'h0;
                end
            end else begin
                fef_run_reg <= 7'h00;
                if (fef_run_reg == 7'd`FPCS_FEF_ONES) begin
                    if (fef_hits_reg != 2'h3) begin
                        fef_hits_reg <= fef_hits_reg + 2'h1;
                    end
                end else begin
                    fef_hits_reg <= 2'h0;
                end
            end
            far_end_fault <= fx_mode && (fef_hits_reg == 2'h3);
            if (!signal_detect || far_end_fault) begin
                link_cnt_reg <= 17'h00000;
                link_up      <= 1'b0;
            end else if (link_cnt_reg == LINK_TOP - 17'h00001) begin
                link_up <= 1'b1;
            end else begin
                link_cnt_reg <= link_cnt_reg + 17'h00001;
            end
        end
    end

    // Aligner, decoder and bad-start detection
    always @* begin
        state_next = state_reg;
        gcnt_next  = gdone ? 3'd0 : gcnt_reg + 3'd1;
        ck_next    = ck_reg + 3'd1;
        tpend_next = tpend_reg;
        idle1_next = idle1_reg;
        pre_next   = 1'b0;
        gen_v      = 1'b0;
        gen_d      = 6'h00;
        fcc_inc    = 1'b0;
        dec        = dec5(grp);
        if (pre_reg) begin
            gen_v = 1'b1;
            gen_d = {2'b10, `FPCS_NIB_PREAMBLE};
        end
        case (state_reg)
            ST_IDLE: begin
                if (armed && !plain) begin
                    state_next = ST_CHECK;
                    ck_next    = 3'd0;
                end
            end
            ST_CHECK: begin
                if (ck_reg == 3'd6) begin
                    gcnt_next  = 3'd0;
                    idle1_next = 1'b0;
                    tpend_next = 1'b0;
                    if (sh_n == `FPCS_JK_PAIR) begin
                        state_next = ST_DATA;
                        gen_v      = 1'b1;
                        gen_d      = {2'b10, `FPCS_NIB_PREAMBLE};
                        pre_next   = 1'b1;
                    end else begin
                        state_next = ST_BAD;
                        fcc_inc    = 1'b1;
                    end
                end
            end
            ST_DATA: begin
                if (gdone) begin
                    if (tpend_reg) begin
                        tpend_next = 1'b0;
                        if (grp == `FPCS_CG_R) begin
                            state_next = ST_IDLE;
                        end else begin
                            gen_v = 1'b1;
                            gen_d = {2'b11, dec[3:0]};
                        end
                    end else if (grp == `FPCS_CG_T) begin
                        tpend_next = 1'b1;
                    end else if (grp == `FPCS_CG_IDLE) begin
                        if (idle1_reg) begin
                            state_next = ST_IDLE;
                        end
                        idle1_next = 1'b1;
                    end else begin
                        idle1_next = 1'b0;
                        gen_v      = 1'b1;
                        gen_d      = {1'b1, dec[4], dec[3:0]};
                    end
                end
            end
            ST_BAD: begin
                if (gdone) begin
                    if (grp == `FPCS_CG_IDLE && idle1_reg) begin
                        state_next = ST_IDLE;
                    end else begin
                        idle1_next = (grp == `FPCS_CG_IDLE);
                        gen_v      = 1'b1;
                        gen_d      = {2'b01, `FPCS_NIB_BAD_SSD};
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (!link_up) begin
            state_next = ST_IDLE;
            gen_v      = 1'b0;
            fcc_inc    = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            sh_reg       <= 10'h000;
            ones_reg     <= 7'h00;
            state_reg    <= ST_IDLE;
            gcnt_reg     <= 3'd0;
            ck_reg       <= 3'd0;
            tpend_reg    <= 1'b0;
            idle1_reg    <= 1'b0;
            pre_reg      <= 1'b0;
            word_reg     <= 6'h00;
            word_vld_reg <= 1'b0;
            rx_overrun   <= 1'b0;
            false_carrier_event_counter <= 16'h0000;
        end else begin
            sh_reg    <= sh_n;
            state_reg <= state_next;
            gcnt_reg  <= gcnt_next;
            ck_reg    <= ck_next;
            tpend_reg <= tpend_next;
            idle1_reg <= idle1_next;
            pre_reg   <= pre_next;
            if (plain) begin
                if (ones_reg != 7'h7F) begin
                    ones_reg <= ones_reg + 7'h01;
                end
            end else begin
                ones_reg <= 7'h00;
            end
            if (fcc_inc) begin
                false_carrier_event_counter <= false_carrier_event_counter + 16'h0001;
            end
            if (gen_v && slot_free) begin
                word_reg     <= gen_d;
                word_vld_reg <= 1'b1;
            end else if (buf_in_ready) begin
                word_vld_reg <= 1'b0;
            end
            if (gen_v && !slot_free) begin
                rx_overrun <= 1'b1;
            end
        end
    end

    fpcs_buf2 #(
        .W(6)
    ) u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (word_vld_reg),
        .in_ready  (buf_in_ready),
        .in_data   (word_reg),
        .out_valid (mii_valid),
        .out_ready (mii_ready),
        .out_data  (buf_out)
    );

    assign mii_rx_dv = buf_out[5];
    assign mii_rx_er = buf_out[4];
    assign mii_rxd   = buf_out[3:0];
    assign mii_crs   = (state_reg != ST_IDLE);

    // Transmit: fault pattern, idles or code bits, then NRZI
    assign tkey   = tlfsr_reg[10] ^ tlfsr_reg[8];
    assign tx_src = fef_tx_on_reg ? (fef_tx_cnt_reg != 7'd`FPCS_FEF_ONES) :
                    (link_up ? tx_code_bit : 1'b1);
    assign tx_scr = fx_mode ? tx_src : (tx_src ^ tkey);

    always @(posedge clk) begin
        if (rst) begin
            tlfsr_reg       <= `FPCS_TX_SEED;
            tx_line         <= 1'b0;
            fef_tx_cnt_reg  <= 7'h00;
            fef_tx_reps_reg <= 2'h0;
            fef_tx_on_reg   <= 1'b0;
        end else begin
            tlfsr_reg <= {tlfsr_reg[9:0], tkey};
            if (tx_scr) begin
                tx_line <= ~tx_line;
            end
            if (fef_tx_on_reg) begin
                if (fef_tx_cnt_reg == 7'd`FPCS_FEF_ONES) begin
                    fef_tx_cnt_reg <= 7'h00;
                    if (fef_tx_reps_reg != 2'h3) begin
                        fef_tx_reps_reg <= fef_tx_reps_reg + 2'h1;
                    end
                    if (signal_detect && fef_tx_reps_reg >= 2'd`FPCS_FEF_REPS - 2'd1) begin
                        fef_tx_on_reg <= 1'b0;
                    end
                end else begin
                    fef_tx_cnt_reg <= fef_tx_cnt_reg + 7'h01;
                end
            end else if (fx_mode && !signal_detect) begin
                fef_tx_on_reg   <= 1'b1;
                fef_tx_cnt_reg  <= 7'h00;
                fef_tx_reps_reg <= 2'h0;
            end
        end
    end
endmodule

`default_nettype wire

// >>> shared/fpcs_defines.vh
`ifndef FPCS_DEFINES_VH
`define FPCS_DEFINES_VH

// Clock rate in MHz
`define FPCS_CLK_MHZ        125
// Link qualification time in us
`define FPCS_LINK_US        395
`define FPCS_LINK_CYC       (`FPCS_LINK_US * `FPCS_CLK_MHZ)
// Descrambler hold interval in us
`define FPCS_HOLD_US        722
`define FPCS_HOLD_CYC       (`FPCS_HOLD_US * `FPCS_CLK_MHZ)

// Descrambled ones for lock: 12 idle groups
`define FPCS_SYNC_ONES      60
// Idle bit times that restart the hold timer
`define FPCS_HOLD_ONES      58
// Ones that arm start-delimiter checking
`define FPCS_ARM_ONES       10

`define FPCS_CG_IDLE        5'h1F
`define FPCS_CG_T           5'h0D
`define FPCS_CG_R           5'h07
`define FPCS_JK_PAIR        10'h311

`define FPCS_NIB_PREAMBLE   4'h5
`define FPCS_NIB_BAD_SSD    4'hE

// Far-end fault: ones per cycle, repetitions
`define FPCS_FEF_ONES       84
`define FPCS_FEF_REPS       3

// Transmit scrambler seed, arbitrary
`define FPCS_TX_SEED        11'h5A5

`endif

// >>> src/fpcs_buf2.v
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer, valid/ready on both sides
module fpcs_buf2 #(
    parameter W = 6
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_reg [0:1];
    reg         wptr_reg;
    reg         rptr_reg;
    reg [1:0]   cnt_reg;
    wire        push;
    wire        pop;

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wptr_reg <= 1'b0;
            rptr_reg <= 1'b0;
            cnt_reg  <= 2'h0;
        end else begin
            if (push) begin
                wptr_reg <= ~wptr_reg;
            end
            if (pop) begin
                rptr_reg <= ~rptr_reg;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 2'h1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 2'h1;
            end
        end
    end
endmodule

`default_nettype wire

// >>> tb/fpcs_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpcs_mac_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       stall,
    input  wire logic       mii_valid,
    output logic            mii_ready,
    input  wire logic [3:0] mii_rxd,
    input  wire logic       mii_rx_dv,
    input  wire logic       mii_rx_er
);
    logic [5:0] words [0:255];
    int         n_words;
    // Bench-driven stall
    assign mii_ready = !stall;
    always @(posedge clk) begin
        if (rst) begin
            n_words <= 0;
        end else if (mii_valid && mii_ready) begin
            words[n_words[7:0]] <= {mii_rx_dv, mii_rx_er, mii_rxd};
            n_words <= n_words + 1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/fpcs_rx_pcs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fpcs_rx_mon #(
    parameter LINK_CYC = 20
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        rx_line,
    input wire logic        signal_detect,
    input wire logic        mii_valid,
    input wire logic        mii_ready,
    input wire logic [3:0]  mii_rxd,
    input wire logic        mii_rx_dv,
    input wire logic        mii_rx_er,
    input wire logic        mii_crs,
    input wire logic        link_up,
    input wire logic        fx_mode,
    input wire logic        far_end_fault,
    input wire logic [15:0] false_carrier_event_counter
);
    logic [15:0] sd_cnt_reg;
    logic [4:0]  ones_reg;
    logic        prev_line_reg;
    wire logic   nrz_bit = rx_line ^ prev_line_reg;
    // Run lengths
    always_ff @(posedge clk) begin
        if (rst) begin
            sd_cnt_reg <= 16'h0000;
            ones_reg   <= 5'h00;
        end else begin
            sd_cnt_reg <= signal_detect ? sd_cnt_reg + {15'h0000, ~&sd_cnt_reg} : 16'h0000;
            ones_reg   <= nrz_bit ? ones_reg + {4'h0, ~&ones_reg} : 5'h00;
        end
        prev_line_reg <= rx_line;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_link_qual; $rose(link_up) |-> sd_cnt_reg >= LINK_CYC - 1; endproperty
    a_link_qual: assert property (p_link_qual) else $error("link up too early");
    property p_sd_drop; !signal_detect ##1 !signal_detect |-> !link_up; endproperty
    a_sd_drop: assert property (p_sd_drop) else $error("link kept without signal");
    property p_fef_link; far_end_fault |-> ##[0:2] !link_up; endproperty
    a_fef_link: assert property (p_fef_link) else $error("link kept on fault");
    property p_crs_nolink; !link_up ##1 !link_up |-> !mii_crs; endproperty
    a_crs_nolink: assert property (p_crs_nolink) else $error("carrier without link");
    property p_bad_word; mii_valid && mii_rx_er && !mii_rx_dv |-> mii_rxd == 4'hE; endproperty
    a_bad_word: assert property (p_bad_word) else $error("bad start nibble wrong");
    property p_cnt_step;
        !$stable(false_carrier_event_counter) |->
            false_carrier_event_counter == $past(false_carrier_event_counter) + 16'h0001;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter step not one");
    property p_cnt_crs; !$stable(false_carrier_event_counter) |-> ##[0:1] mii_crs; endproperty
    a_cnt_crs: assert property (p_cnt_crs) else $error("count without carrier");
    property p_idle_end; fx_mode && ones_reg >= 5'h12 |-> !mii_crs; endproperty
    a_idle_end: assert property (p_idle_end) else $error("carrier kept over idles");
    property p_hold;
        mii_valid && !mii_ready |=> mii_valid && $stable(mii_rxd) && $stable(mii_rx_dv)
            && $stable(mii_rx_er);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed while stalled");
endmodule
bind fpcs_rx_pcs fpcs_rx_mon #(.LINK_CYC(LINK_CYC)) mon_u (
    .clk(clk), .rst(rst), .rx_line(rx_line), .signal_detect(signal_detect),
    .mii_valid(mii_valid), .mii_ready(mii_ready), .mii_rxd(mii_rxd),
    .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_crs(mii_crs), .link_up(link_up),
    .fx_mode(fx_mode), .far_end_fault(far_end_fault),
    .false_carrier_event_counter(false_carrier_event_counter)
);
`default_nettype wire

// >>> tb/fpcs_rx_pcs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fpcs_rx_pcs_bench;
    localparam int LINK = 20;
    localparam int HOLD = 200;
    localparam logic [4:0] CODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic        clk           = 1'b0;
    logic        rst           = 1'b1;
    logic        rx_line       = 1'b0;
    logic        signal_detect = 1'b0;
    logic        fx_strap      = 1'b0;
    logic        fx_select     = 1'b0;
    logic        stall         = 1'b0;
    logic        scr           = 1'b0;
    logic [10:0] lfsr          = 11'h1AB;
    logic        tx_line, mii_valid, mii_ready, mii_rx_dv, mii_rx_er, mii_crs;
    logic        link_up, descr_locked, fx_mode, far_end_fault, rx_overrun;
    logic [3:0]  mii_rxd;
    logic [15:0] fcc;
    int          num_errors    = 0;
    int          total_checks  = 0;
    int          cyc           = 0;
    always #4 clk = ~clk;
    fpcs_rx_pcs #(.LINK_CYC(LINK), .HOLD_CYC(HOLD)) dut_u (
        .clk(clk), .rst(rst), .rx_line(rx_line), .signal_detect(signal_detect),
        .fx_strap(fx_strap), .fx_select(fx_select), .tx_code_bit(1'b0), .tx_line(tx_line),
        .mii_valid(mii_valid), .mii_ready(mii_ready), .mii_rxd(mii_rxd),
        .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_crs(mii_crs), .link_up(link_up),
        .descr_locked(descr_locked), .fx_mode(fx_mode), .far_end_fault(far_end_fault),
        .rx_overrun(rx_overrun), .false_carrier_event_counter(fcc));
    fpcs_mac_model mac_u (
        .clk(clk), .rst(rst), .stall(stall), .mii_valid(mii_valid), .mii_ready(mii_ready),
        .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One plain bit per cycle, NRZI on the line
    task automatic bit_out(input logic b);
        logic n;
        @(negedge clk);
        n = lfsr[10] ^ lfsr[8];
        if (scr) lfsr = {lfsr[9:0], n};
        if (b ^ (scr & n)) rx_line = ~rx_line;
    endtask
    task automatic grp(input logic [4:0] g);
        for (int i = 4; i >= 0; i--) bit_out(g[i]);
    endtask
    task automatic idles(input int n);
        repeat (n) grp(5'h1F);
    endtask
    task automatic do_reset(input logic s);
        rst = 1'b1;
        fx_strap = s;
        signal_detect = 1'b0;
        repeat (6) bit_out(1'b1);
        rst = 1'b0;
    endtask
    task automatic qualify;
        int n = 0;
        bit_out(1'b1);
        signal_detect = 1'b1;
        while (link_up !== 1'b1 && n < 100) begin
            bit_out(1'b1);
            n++;
        end
        chk(16'(n >= LINK - 1 && n <= LINK + 2), 16'h0001, "qualify time");
    endtask
    task automatic t_strap_link;
        do_reset(1'b1);
        chk(fx_mode, 1'b1, "mode by strap");
        qualify();
    endtask
    task automatic t_frame;
        int          b;
        logic [15:0] c0;
        b = mac_u.n_words;
        c0 = fcc;
        idles(4);
        grp(5'h18);
        grp(5'h11);
        for (int i = 0; i < 16; i++) begin
            stall = (i == 0);
            grp(CODE[i]);
        end
        grp(5'h0D);
        grp(5'h07);
        idles(4);
        chk(16'(mac_u.n_words - b), 16'h0012, "frame words");
        chk(mac_u.words[b], 6'h25, "preamble one");
        chk(mac_u.words[b + 1], 6'h25, "preamble two");
        for (int i = 0; i < 16; i++) chk(mac_u.words[b + 2 + i], {2'b10, 4'(i)}, "data");
        chk(fcc, c0, "no false carrier");
        chk(rx_overrun, 1'b0, "no overrun");
    endtask
    task automatic t_bad;
        int          b;
        logic [15:0] c0;
        b = mac_u.n_words;
        c0 = fcc;
        idles(4);
        grp(5'h14);
        grp(5'h14);
        idles(4);
        chk(fcc, c0 + 16'h0001, "fcc count");
        chk(16'(mac_u.n_words > b), 16'h0001, "bad words");
        for (int i = b; i < mac_u.n_words; i++) chk(mac_u.words[i], 6'h1E, "bad word");
        chk(mii_crs, 1'b0, "carrier end");
    endtask
    task automatic t_fef_tx;
        int   z0 = -1;
        int   z1 = -1;
        logic prev;
        bit_out(1'b1);
        signal_detect = 1'b0;
        prev = tx_line;
        for (int i = 0; i < 300; i++) begin
            bit_out(1'b1);
            if (i >= 100 && tx_line === prev && z0 < 0) z0 = i;
            else if (i >= 100 && tx_line === prev && z1 < 0) z1 = i;
            prev = tx_line;
        end
        chk(link_up, 1'b0, "link no signal");
        chk(16'(z1 - z0), 16'd85, "fault cycle length");
        qualify();
    endtask
    task automatic t_fef_rx;
        int   k = 0;
        logic prev;
        repeat (4) begin
            repeat (84) bit_out(1'b1);
            bit_out(1'b0);
        end
        repeat (3) bit_out(1'b1);
        chk(far_end_fault, 1'b1, "fault seen");
        prev = tx_line;
        repeat (20) begin
            bit_out(1'b1);
            k += (tx_line === prev);
            prev = tx_line;
        end
        chk(link_up, 1'b0, "link on fault");
        chk(16'(k), 16'h0000, "idles on fault");
        repeat (200) bit_out(1'b1);
        chk(far_end_fault, 1'b0, "fault cleared");
        chk(link_up, 1'b1, "link back");
    endtask
    task automatic t_overrun;
        stall = 1'b1;
        idles(2);
        grp(5'h18);
        grp(5'h11);
        for (int i = 0; i < 6; i++) grp(CODE[i]);
        idles(4);
        chk(mii_valid, 1'b1, "buffer full");
        chk(rx_overrun, 1'b1, "overrun flag");
        stall = 1'b0;
        idles(2);
        chk(mii_valid, 1'b0, "buffer drained");
    endtask
    task automatic t_copper;
        int k = 0;
        do_reset(1'b0);
        chk(fx_mode, 1'b0, "strap low");
        fx_select = 1'b1;
        bit_out(1'b1);
        chk(fx_mode, 1'b1, "mode by select");
        fx_select = 1'b0;
        scr = 1'b1;
        qualify();
        repeat (100) bit_out(1'b1);
        chk(descr_locked, 1'b1, "lock on idles");
        repeat (600) begin
            bit_out(1'b1);
            k += (descr_locked !== 1'b1);
        end
        chk(16'(k), 16'h0000, "lock held by idles");
        repeat (130) bit_out(1'b0);
        chk(descr_locked, 1'b1, "lock before expiry");
        repeat (90) bit_out(1'b0);
        chk(descr_locked, 1'b0, "lock dropped");
        repeat (100) bit_out(1'b1);
        chk(descr_locked, 1'b1, "lock regained");
    endtask
    initial begin
        t_strap_link();
        t_frame();
        t_bad();
        t_fef_tx();
        t_fef_rx();
        t_overrun();
        t_copper();
        tally_and_finish();
    end
endmodule
`default_nettype wire
